//--- rtl/cacm_pkg.sv
`default_nettype none
package cacm_pkg;

   // ***************************************************
   // Bus geometry and register indices (byte addr = 4 x index)
   // ***************************************************
   localparam int          ADDR_W        = 12;  // AXI address width
   localparam int          IDX_W         = 10;  // Word index width
   localparam logic [9:0]  CTRL_IDX      = 10'h02d; // Control register
   localparam logic [9:0]  DIV_A_IDX     = 10'h02e; // Divider a ratio
   localparam logic [9:0]  DIV_B_IDX     = 10'h02f; // Divider b ratio
   localparam logic [9:0]  FEED_IDX      = 10'h030; // Divider feed select
   localparam logic [9:0]  STAT_IDX      = 10'h031; // Live state, read only

   // ***************************************************
   // Field positions of the control register and the feed register
   // ***************************************************
   localparam int          PRE_B_LSB     = 6;   // Synth b prescale select
   localparam int          PRE_A_LSB     = 4;   // Synth a prescale select
   localparam int          PIN_B_LSB     = 2;   // Aux pin b source select
   localparam int          PIN_A_LSB     = 0;   // Aux pin a source select
   localparam int          FEED_A_BIT    = 0;   // Divider a feed bit
   localparam int          FEED_B_BIT    = 1;   // Divider b feed bit

   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [7:0]  CTRL_RST      = 8'h0a; // Pins on status, prescale off
   localparam logic [7:0]  DIV_RST       = 8'h00; // Dividers disabled
   localparam logic [1:0]  FEED_RST      = 2'h2;  // a from synth a, b from b

   // ***************************************************
   // Ratios and codes
   // ***************************************************
   localparam logic [8:0]  PRE4_RATIO    = 9'h004; // Prescale by 4
   localparam logic [8:0]  PRE5_RATIO    = 9'h005; // Prescale by 5
   localparam logic [7:0]  DIV_OFF_CODE  = 8'h00;  // Divider disabled
   localparam logic [7:0]  DIV_MIN_CODE  = 8'h05;  // Codes 1..5 floor
   localparam logic [8:0]  DIV_MIN_RATIO = 9'h006; // Ratio of codes 1..5
   localparam logic [1:0]  RESP_OKAY     = 2'h0;   // AXI okay
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;   // AXI slave error

   typedef enum logic [1:0] {
      PRE_OFF  = 2'b00,   // No clock to the dividers
      PRE_DIV4 = 2'b01,   // Divide by 4
      PRE_DIV5 = 2'b10,   // Divide by 5
      PRE_RSVD = 2'b11    // Reserved, acts as off
   } cacm_prescale_t;

   typedef enum logic [1:0] {
      PIN_DIV_A  = 2'b00, // Clock from divider a
      PIN_DIV_B  = 2'b01, // Clock from divider b
      PIN_STATUS = 2'b10, // Normal status signalling
      PIN_OFF    = 2'b11  // Pin disabled
   } cacm_pin_src_t;

endpackage : cacm_pkg
`default_nettype wire

//--- rtl/cacm_div_if.sv
`default_nettype none
interface cacm_div_if;
   logic       tick_in;   // One-cycle input tick
   logic       enable;    // Unit runs while high
   logic [8:0] ratio;     // Division ratio, 1..256
   logic       tick_out;  // One-cycle tick per period
   logic       level;     // Divided clock level

   modport unit (input tick_in, input enable, input ratio,
                 output tick_out, output level);
   modport ctrl (output tick_in, output enable, output ratio,
                 input tick_out, input level);
endinterface : cacm_div_if
`default_nettype wire

//--- rtl/cacm_tick_div.sv
`default_nettype none
module cacm_tick_div (
   input  wire logic clk_sys,    // System clock
   input  wire logic rst,        // Synchronous reset
   cacm_div_if.unit  bus         // Tick in, ratio, tick and level out
);

   // ***************************************************
   // Tick counter
   // ***************************************************
   logic [7:0] cnt_reg;          // Ticks seen in the current period
   logic [7:0] last_cnt;         // Count that ends the period
   logic [7:0] half_cnt;         // Count where the level falls

   assign last_cnt = 8'(bus.ratio - 9'h001);
   assign half_cnt = bus.ratio[8:1];

   // Counts input ticks, wraps at the ratio, shapes the level
   always_ff @(posedge clk_sys) begin
      if (rst || !bus.enable) begin
         cnt_reg      <= 8'h00;
         bus.level    <= 1'b0;   // Stopped unit drives low
         bus.tick_out <= 1'b0;
      end else if (bus.tick_in) begin
         // Wraps at or past the end, so a ratio lowered mid-count
         // cannot send the counter round all 256 values
         if (cnt_reg >= last_cnt) begin
            cnt_reg      <= 8'h00;
            bus.level    <= 1'b1;   // High for the first half
            bus.tick_out <= 1'b1;
         end else begin
            cnt_reg      <= cnt_reg + 8'h01;
            bus.tick_out <= 1'b0;
            if (cnt_reg + 8'h01 == half_cnt) begin
               bus.level <= 1'b0;   // Low for the second half
            end
         end
      end else begin
         bus.tick_out <= 1'b0;
      end
   end

endmodule // cacm_tick_div
`default_nettype wire

//--- rtl/cacm_aux_clock_mux.sv
// Functional notes
// - Each aux pin takes divider a or b
// - Dividers fed from synth a or b prescaler
// - Synth b prescale: off, /4, /5, reserved
// - Synth a prescale: off, /4, /5, reserved
// - Pin b source: div a, div b, status, off
// - Pin a source: div a, div b, status, off
// - Ratio code: 0 off, 1-5 six, else N+1
`default_nettype none
module cacm_aux_clock_mux (
   input  wire logic        clk_sys,        // System clock, 40 MHz
   input  wire logic        rst,            // Synchronous reset, high
   input  wire logic [11:0] s_axi_awaddr,   // Write address
   input  wire logic        s_axi_awvalid,  // Write address valid
   output logic             s_axi_awready,  // Write address ready
   input  wire logic [31:0] s_axi_wdata,    // Write data
   input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes
   input  wire logic        s_axi_wvalid,   // Write data valid
   output logic             s_axi_wready,   // Write data ready
   output logic [1:0]       s_axi_bresp,    // Write response
   output logic             s_axi_bvalid,   // Write response valid
   input  wire logic        s_axi_bready,   // Write response ready
   input  wire logic [11:0] s_axi_araddr,   // Read address
   input  wire logic        s_axi_arvalid,  // Read address valid
   output logic             s_axi_arready,  // Read address ready
   output logic [31:0]      s_axi_rdata,    // Read data
   output logic [1:0]       s_axi_rresp,    // Read response
   output logic             s_axi_rvalid,   // Read data valid
   input  wire logic        s_axi_rready,   // Read data ready
   input  wire logic        synth_a_clk,    // Synthesizer a clock pin
   input  wire logic        synth_b_clk,    // Synthesizer b clock pin
   input  wire logic        status_a_in,    // Status signal for pin a
   input  wire logic        status_b_in,    // Status signal for pin b
   output logic             aux_pin_a,      // Aux pin a level
   output logic             aux_pin_a_oe,   // Aux pin a drive enable
   output logic             aux_pin_b,      // Aux pin b level
   output logic             aux_pin_b_oe    // Aux pin b drive enable
);

   // ***************************************************
   // Registers and bus state
   // ***************************************************
   logic [7:0]  ctrl_reg;        // Control register
   logic [7:0]  div_a_reg;       // Divider a ratio code
   logic [7:0]  div_b_reg;       // Divider b ratio code
   logic [1:0]  feed_reg;        // Divider feed selects
   logic        aw_held_reg;     // Write address captured
   logic        w_held_reg;      // Write data captured
   logic [9:0]  aw_idx_reg;      // Captured write index
   logic [7:0]  wdata_reg;       // Captured write byte
   logic        wstrb0_reg;      // Captured low lane strobe
   logic        do_write;        // Both halves present, perform write
   logic        wr_mapped;       // Write index is writable
   logic [9:0]  ar_idx;          // Read index

   cacm_pkg::cacm_prescale_t pre_a; // Synth a prescale select
   cacm_pkg::cacm_prescale_t pre_b; // Synth b prescale select
   cacm_pkg::cacm_pin_src_t  src_a; // Pin a source select
   cacm_pkg::cacm_pin_src_t  src_b; // Pin b source select

   assign pre_b = cacm_pkg::cacm_prescale_t'(
      ctrl_reg[cacm_pkg::PRE_B_LSB +: 2]);
   assign pre_a = cacm_pkg::cacm_prescale_t'(
      ctrl_reg[cacm_pkg::PRE_A_LSB +: 2]);
   assign src_b = cacm_pkg::cacm_pin_src_t'(
      ctrl_reg[cacm_pkg::PIN_B_LSB +: 2]);
   assign src_a = cacm_pkg::cacm_pin_src_t'(
      ctrl_reg[cacm_pkg::PIN_A_LSB +: 2]);

   // ***************************************************
   // AXI4-Lite write side
   // ***************************************************
   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready  = !w_held_reg;
   assign do_write      = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wr_mapped     = (aw_idx_reg == cacm_pkg::CTRL_IDX)  ||
                          (aw_idx_reg == cacm_pkg::DIV_A_IDX) ||
                          (aw_idx_reg == cacm_pkg::DIV_B_IDX) ||
                          (aw_idx_reg == cacm_pkg::FEED_IDX);

   // Captures the write address, freed once the write is done
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aw_held_reg <= 1'b0;
         aw_idx_reg  <= 10'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_idx_reg  <= s_axi_awaddr[11:2];
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   // Captures the write data, freed once the write is done
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         w_held_reg <= 1'b0;
         wdata_reg  <= 8'h00;
         wstrb0_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         wdata_reg  <= s_axi_wdata[7:0];
         wstrb0_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   // Write response, error for an index with no writable register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= cacm_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? cacm_pkg::RESP_OKAY
                                   : cacm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Register file update, low byte lane only
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_reg  <= cacm_pkg::CTRL_RST;
         div_a_reg <= cacm_pkg::DIV_RST;
         div_b_reg <= cacm_pkg::DIV_RST;
         feed_reg  <= cacm_pkg::FEED_RST;
      end else if (do_write && wstrb0_reg) begin
         case (aw_idx_reg)
            cacm_pkg::CTRL_IDX:  ctrl_reg  <= wdata_reg;
            cacm_pkg::DIV_A_IDX: div_a_reg <= wdata_reg;
            cacm_pkg::DIV_B_IDX: div_b_reg <= wdata_reg;
            cacm_pkg::FEED_IDX:  feed_reg  <= wdata_reg[1:0];
            default: ;            // Unmapped, nothing stored
         endcase
      end
   end

   // ***************************************************
   // AXI4-Lite read side
   // ***************************************************
   logic [7:0] stat_word;        // Live state readback
   logic [3:0] lvl;              // Unit levels, see generate below
   logic [3:0] ena;              // Unit enables

   assign s_axi_arready = !s_axi_rvalid;
   assign ar_idx        = s_axi_araddr[11:2];
   assign stat_word     = {2'h0, aux_pin_b, aux_pin_a, ena};

   // Read data captured on the address handshake
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= cacm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= cacm_pkg::RESP_OKAY;
         case (ar_idx)
            cacm_pkg::CTRL_IDX:  s_axi_rdata <= {24'h0, ctrl_reg};
            cacm_pkg::DIV_A_IDX: s_axi_rdata <= {24'h0, div_a_reg};
            cacm_pkg::DIV_B_IDX: s_axi_rdata <= {24'h0, div_b_reg};
            cacm_pkg::FEED_IDX:  s_axi_rdata <= {30'h0, feed_reg};
            cacm_pkg::STAT_IDX:  s_axi_rdata <= {24'h0, stat_word};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= cacm_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ***************************************************
   // Synthesizer clock sampling
   // ***************************************************
   logic [1:0] sync1_reg;        // First synchroniser stage
   logic [1:0] sync2_reg;        // Second synchroniser stage
   logic [1:0] prev_reg;         // Previous synchronised level
   logic [1:0] synth_edge;       // Rising edge ticks

   // Two-flop synchronisers and edge history for both synth clocks
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_reg <= 2'b00;
         sync2_reg <= 2'b00;
         prev_reg  <= 2'b00;
      end else begin
         sync1_reg <= {synth_b_clk, synth_a_clk};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   assign synth_edge = sync2_reg & ~prev_reg;

   // ***************************************************
   // Prescalers (units 0, 1) and dividers (units 2, 3)
   // ***************************************************
   logic       [3:0] tin;        // Unit tick inputs
   logic       [3:0] tout;       // Unit tick outputs
   logic [3:0] [8:0] rat;        // Unit ratios
   logic             feed_a_t;   // Tick feeding divider a
   logic             feed_b_t;   // Tick feeding divider b
   logic             feed_a_on;  // Prescaler feeding divider a runs
   logic             feed_b_on;  // Prescaler feeding divider b runs

   // Maps a ratio code to its division ratio
   function automatic logic [8:0] code_ratio(input logic [7:0] code);
      if (code <= cacm_pkg::DIV_MIN_CODE) begin
         code_ratio = cacm_pkg::DIV_MIN_RATIO;
      end else begin
         code_ratio = {1'b0, code} + 9'h001;
      end
   endfunction

   // Reserved and off codes both stop the prescaler
   assign ena[0] = (pre_a == cacm_pkg::PRE_DIV4) ||
                   (pre_a == cacm_pkg::PRE_DIV5);
   assign ena[1] = (pre_b == cacm_pkg::PRE_DIV4) ||
                   (pre_b == cacm_pkg::PRE_DIV5);
   assign rat[0] = (pre_a == cacm_pkg::PRE_DIV4) ? cacm_pkg::PRE4_RATIO
                                                 : cacm_pkg::PRE5_RATIO;
   assign rat[1] = (pre_b == cacm_pkg::PRE_DIV4) ? cacm_pkg::PRE4_RATIO
                                                 : cacm_pkg::PRE5_RATIO;
   assign tin[1:0] = synth_edge;

   // Each divider takes synth a or synth b prescaler output
   assign feed_a_t  = feed_reg[cacm_pkg::FEED_A_BIT] ? tout[1] : tout[0];
   assign feed_b_t  = feed_reg[cacm_pkg::FEED_B_BIT] ? tout[1] : tout[0];
   assign feed_a_on = feed_reg[cacm_pkg::FEED_A_BIT] ? ena[1] : ena[0];
   assign feed_b_on = feed_reg[cacm_pkg::FEED_B_BIT] ? ena[1] : ena[0];
   assign tin[2]    = feed_a_t;
   assign tin[3]    = feed_b_t;
   assign ena[2]    = feed_a_on && (div_a_reg != cacm_pkg::DIV_OFF_CODE);
   assign ena[3]    = feed_b_on && (div_b_reg != cacm_pkg::DIV_OFF_CODE);
   assign rat[2]    = code_ratio(div_a_reg);
   assign rat[3]    = code_ratio(div_b_reg);

   // One counting unit per prescaler and divider
   for (genvar g = 0; g < 4; g++) begin : g_unit
      cacm_div_if u_if ();
      assign u_if.tick_in = tin[g];
      assign u_if.enable  = ena[g];
      assign u_if.ratio   = rat[g];
      assign tout[g]      = u_if.tick_out;
      assign lvl[g]       = u_if.level;
      cacm_tick_div u_div (
         .clk_sys (clk_sys),
         .rst     (rst),
         .bus     (u_if.unit)
      );
   end

   // ***************************************************
   // Aux pin source selection
   // ***************************************************
   // Picks divider clock, status or off for each pin, registered
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aux_pin_a    <= 1'b0;
         aux_pin_a_oe <= 1'b0;
         aux_pin_b    <= 1'b0;
         aux_pin_b_oe <= 1'b0;
      end else begin
         aux_pin_a_oe <= (src_a != cacm_pkg::PIN_OFF);
         aux_pin_b_oe <= (src_b != cacm_pkg::PIN_OFF);
         case (src_a)
            cacm_pkg::PIN_DIV_A:  aux_pin_a <= lvl[2];
            cacm_pkg::PIN_DIV_B:  aux_pin_a <= lvl[3];
            cacm_pkg::PIN_STATUS: aux_pin_a <= status_a_in;
            default:              aux_pin_a <= 1'b0;
         endcase
         case (src_b)
            cacm_pkg::PIN_DIV_A:  aux_pin_b <= lvl[2];
            cacm_pkg::PIN_DIV_B:  aux_pin_b <= lvl[3];
            cacm_pkg::PIN_STATUS: aux_pin_b <= status_b_in;
            default:              aux_pin_b <= 1'b0;
         endcase
      end
   end

endmodule // cacm_aux_clock_mux
`default_nettype wire

//--- bench/cacm_aux_clock_mux_asserts.sv
`default_nettype none
// ***********************************************
// Port checker for the aux clock mux
// ***********************************************
module cacm_aux_clock_mux_asserts (
   input wire logic        clk_sys,       // System clock
   input wire logic        rst,           // Synchronous reset
   input wire logic [11:0] s_axi_awaddr,  // Write address
   input wire logic        s_axi_awvalid, // Write address valid
   input wire logic        s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata,   // Write data
   input wire logic [3:0]  s_axi_wstrb,   // Write strobes
   input wire logic        s_axi_wvalid,  // Write data valid
   input wire logic        s_axi_wready,  // Write data ready
   input wire logic        s_axi_bvalid,  // Write response valid
   input wire logic        s_axi_arvalid, // Read address valid
   input wire logic        s_axi_arready, // Read address ready
   input wire logic [31:0] s_axi_rdata,   // Read data
   input wire logic        s_axi_rvalid,  // Read data valid
   input wire logic        s_axi_rready,  // Read data ready
   input wire logic        status_a_in,   // Status for pin a
   input wire logic        status_b_in,   // Status for pin b
   input wire logic        aux_pin_a,     // Pin a level
   input wire logic        aux_pin_a_oe,  // Pin a enable
   input wire logic        aux_pin_b,     // Pin b level
   input wire logic        aux_pin_b_oe   // Pin b enable
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] shadow;   // Mirror of the control register
   logic [3:0] quiet;    // Cycles since the last control write
   logic       wr_ctl;   // Control write taken this edge
   logic       pre_dead; // Both prescalers stopped
   assign wr_ctl = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready && s_axi_wstrb[0] &&
      s_axi_awaddr[11:2] == cacm_pkg::CTRL_IDX;
   assign pre_dead = (shadow[5:4] == 2'h0 || shadow[5:4] == 2'h3) &&
      (shadow[7:6] == 2'h0 || shadow[7:6] == 2'h3);
   // Track the control value and how long it has stood
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         shadow <= cacm_pkg::CTRL_RST;
         quiet <= 4'h0;
      end else if (wr_ctl) begin
         shadow <= s_axi_wdata[7:0];
         quiet <= 4'h0;
      end else if (quiet != 4'hf) begin
         quiet <= quiet + 4'h1;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_resp;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   property p_wr_resp;
      s_wr_take |=> s_wr_resp;
   endproperty
   a_wr_resp: assert property (p_wr_resp)
      else $error("Write response not on second cycle");
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=>
         s_axi_rvalid && !s_axi_arready && s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_rd_resp: assert property (p_rd_resp)
      else $error("Read data not presented next cycle");
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("Read data dropped before taken");
   property p_pin_a_off;
      quiet >= 4'h4 && shadow[1:0] == 2'h3 |-> !aux_pin_a_oe && !aux_pin_a;
   endproperty
   a_pin_a_off: assert property (p_pin_a_off)
      else $error("Pin a driven while disabled");
   property p_pin_b_off;
      quiet >= 4'h4 && shadow[3:2] == 2'h3 |-> !aux_pin_b_oe && !aux_pin_b;
   endproperty
   a_pin_b_off: assert property (p_pin_b_off)
      else $error("Pin b driven while disabled");
   property p_pin_a_stat;
      quiet >= 4'h4 && shadow[1:0] == 2'h2 |->
         aux_pin_a_oe && aux_pin_a == $past(status_a_in);
   endproperty
   a_pin_a_stat: assert property (p_pin_a_stat)
      else $error("Pin a not following status");
   property p_pin_b_stat;
      quiet >= 4'h4 && shadow[3:2] == 2'h2 |->
         aux_pin_b_oe && aux_pin_b == $past(status_b_in);
   endproperty
   a_pin_b_stat: assert property (p_pin_b_stat)
      else $error("Pin b not following status");
   property p_pre_off;
      quiet == 4'hf && pre_dead |->
         (shadow[1] || (aux_pin_a_oe && !aux_pin_a)) &&
         (shadow[3] || (aux_pin_b_oe && !aux_pin_b));
   endproperty
   a_pre_off: assert property (p_pre_off)
      else $error("Clock seen with both prescalers stopped");
endmodule // cacm_aux_clock_mux_asserts
bind cacm_aux_clock_mux cacm_aux_clock_mux_asserts
   cacm_aux_clock_mux_asserts_i (.*);
`default_nettype wire

//--- bench/cacm_aux_clock_mux_test.sv
`default_nettype none
module cacm_aux_clock_mux_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************************
   // Stimulus, design and clocks
   // ***********************************************
   localparam logic [11:0] A_CTRL = {cacm_pkg::CTRL_IDX, 2'h0};
   localparam logic [11:0] A_DA = {cacm_pkg::DIV_A_IDX, 2'h0};
   localparam logic [11:0] A_DB = {cacm_pkg::DIV_B_IDX, 2'h0};
   localparam logic [11:0] A_FEED = {cacm_pkg::FEED_IDX, 2'h0};
   logic        clk_sys = 1'b0, rst = 1'b1, sa = 1'b0, sb = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;   // Addresses
   logic [31:0] wdata = 32'h0, seed = 32'h35;     // Data, random state
   logic [3:0]  wstrb = 4'h0;                     // Strobes
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, st_a = 1'b0, st_b = 1'b0;
   wire logic   awready, wready, bvalid, arready, rvalid, pa, pa_oe, pb, pb_oe;
   wire logic [1:0]  bresp, rresp;                // Responses
   wire logic [31:0] rdata;                       // Read data
   int          err_total = 0, num_checks = 0, cyc = 0;
   cacm_aux_clock_mux cacm_aux_clock_mux_i (.clk_sys(clk_sys), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .synth_a_clk(sa),
      .synth_b_clk(sb), .status_a_in(st_a), .status_b_in(st_b),
      .aux_pin_a(pa), .aux_pin_a_oe(pa_oe), .aux_pin_b(pb),
      .aux_pin_b_oe(pb_oe));
   always #12.5 clk_sys = ~clk_sys;
   // Synth clocks: a every 4 cycles, b every 6
   always @(posedge clk_sys) begin
      cyc <= (cyc + 1) % 12;
      sa <= (cyc % 4) >= 2;
      sb <= (cyc % 6) >= 3;
   end
   // ***********************************************
   // Model, compare and bus tasks
   // ***********************************************
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   // Divider period in system cycles, 0 when stopped
   function automatic int mp(int c, int code, int f);
      int pre;
      pre = f ? (c >> 6) & 3 : (c >> 4) & 3;
      if (code == 0 || pre == 0 || pre == 3) return 0;
      return (pre == 1 ? 4 : 5) * (code <= 5 ? 6 : code + 1) * (f ? 6 : 4);
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
      end
   endtask
   // Write one word and compare the response
   task automatic wr(logic [11:0] a, logic [31:0] d,
                     logic [1:0] er = cacm_pkg::RESP_OKAY);
      bit ap = 1, wp = 1, got = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!got) begin
         @(posedge clk_sys);
         if (ap && awready === 1'b1) begin
            awvalid <= 1'b0;
            ap = 0;
         end
         if (wp && wready === 1'b1) begin
            wvalid <= 1'b0;
            wp = 0;
         end
         if (bvalid === 1'b1) begin
            got = 1;
            bready <= 1'b0;
            chk("write resp", er, bresp);
         end
      end
      @(posedge clk_sys);
   endtask
   // Read one word, accept it one cycle late, compare
   task automatic rd(logic [11:0] a, logic [31:0] e,
                     logic [1:0] er = cacm_pkg::RESP_OKAY);
      bit got = 0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!got) begin
         @(posedge clk_sys);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1 && rready) begin
            got = 1;
            chk("read data", e, rdata);
            chk("read resp", er, rresp);
         end else if (rvalid === 1'b1) rready <= 1'b1;
      end
      rready <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Period between the second and third rising edge of a pin
   task automatic per(input int b, output int p);
      int n = 0, e = 0, t0;
      bit prev = 1, cur;
      p = 0;
      while (n < 1000 && e < 3) begin
         @(posedge clk_sys);
         n++;
         cur = (b ? pb : pa) === 1'b1;
         if (cur && !prev) begin
            e++;
            if (e == 2) t0 = n;
            if (e == 3) p = n - t0;
         end
         prev = cur;
      end
   endtask
   task automatic test_done;
      $display("Checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Watchdog for a hung run
   initial begin
      #(60000 * 25);
      err_total++;
      test_done;
   end
   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      int tb[6][4] = '{'{148, 2, 6, 2}, '{145, 2, 6, 2}, '{148, 2, 6, 1},
                      '{180, 2, 1, 2}, '{196, 2, 6, 2}, '{148, 0, 5, 2}};
      int p, c, s, e;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd(A_CTRL, 32'h0a);
      rd(A_DA, 32'h00);
      rd(A_FEED, 32'h02);
      rd(12'h400, 32'h00, cacm_pkg::RESP_SLVERR);
      wr({cacm_pkg::STAT_IDX, 2'h0}, 32'h01, cacm_pkg::RESP_SLVERR);
      repeat (4) begin
         seed = xs(seed);
         wr(A_CTRL, seed);
         rd(A_CTRL, seed & 32'hff);
      end
      wr(A_CTRL, 32'h0a);
      repeat (4) @(posedge clk_sys);
      repeat (8) begin
         seed = xs(seed);
         st_a <= seed[0];
         st_b <= seed[1];
         repeat (2) @(posedge clk_sys);
         chk("pin a status", {1'b1, seed[0]}, {pa_oe, pa});
         chk("pin b status", {1'b1, seed[1]}, {pb_oe, pb});
      end
      wr(A_CTRL, 32'h0f);
      repeat (4) @(posedge clk_sys);
      chk("pin a off", 0, {pa_oe, pa});
      chk("pin b off", 0, {pb_oe, pb});
      for (int i = 0; i < 6; i++) begin
         c = tb[i][0];
         wr(A_DA, tb[i][1]);
         wr(A_DB, tb[i][2]);
         wr(A_FEED, tb[i][3]);
         wr(A_CTRL, c);
         for (int k = 0; k < 2; k++) begin
            s = (c >> (2 * k)) & 3;
            e = s == 0 ? mp(c, tb[i][1], tb[i][3] & 1) :
                s == 1 ? mp(c, tb[i][2], (tb[i][3] >> 1) & 1) : 0;
            per(k, p);
            chk(k ? "pin b period" : "pin a period", e, p);
            chk("pin enable", 1, k ? pb_oe : pa_oe);
         end
      end
      test_done;
   end
endmodule // cacm_aux_clock_mux_test
`default_nettype wire
